/* rtl/dbw_write_port.v */
// double-data-rate write port with byte-lane masking and a small array
// assumes one clock; phase input marks positive/negative half beats
`timescale 1ns/100ps
`default_nettype none
`include "dbw_map.vh"

module dbw_write_port #(
  parameter LANES     = `DBW_LANES,
  parameter ADDR_BITS = `DBW_ADDR_BITS
) (
  // clock and reset
  input  wire                          clk,
  input  wire                          rst_n,
  // beat phase: high on positive-clock beat, low on negative beat
  input  wire                          posBeat,
  // write port
  input  wire                          write_port_sel_n,
  input  wire [LANES-1:0]              byte_lane_mask_n,
  input  wire [LANES*`DBW_LANE_BITS-1:0] writeData,
  input  wire [ADDR_BITS-1:0]          writeAddr,
  // read port
  input  wire                          readSel_n,
  input  wire [ADDR_BITS-1:0]          readAddr,
  output wire [LANES*`DBW_LANE_BITS-1:0] readData,
  output wire                          readDataOe,
  // status
  output wire                          writeBusy,
  output wire                          writeDone
);

  // derived sizes
  localparam WB       = LANES*`DBW_LANE_BITS;
  localparam DEP      = 1 << ADDR_BITS;

  // burst step at address width, so the wrap at the top is explicit
  localparam [ADDR_BITS-1:0] STEP = `DBW_ADDR_STEP;

  // burst states, one-hot
  localparam ST_IDLE  = 3'h1;
  localparam ST_ADDR  = 3'h2;
  localparam ST_WORD1 = 3'h4;

  // storage; not cleared by reset, like the real array
  reg  [WB-1:0]        mem [0:DEP-1];

  // burst control
  reg  [2:0]           state_reg;
  reg  [2:0]           state_next;
  reg  [WB-1:0]        word0_reg;
  reg  [WB-1:0]        word0_next;
  reg  [LANES-1:0]     mask0_reg;
  reg  [LANES-1:0]     mask0_next;
  reg  [WB-1:0]        word1_reg;
  reg  [WB-1:0]        word1_next;
  reg  [LANES-1:0]     mask1_reg;
  reg  [LANES-1:0]     mask1_next;
  reg  [ADDR_BITS-1:0] addr_reg;
  reg  [ADDR_BITS-1:0] addr_next;
  reg                  done_reg;
  reg                  done_next;

  // read path
  reg  [WB-1:0]        rdData_reg;
  reg  [WB-1:0]        rdData_next;
  reg                  rdOe_reg;
  reg                  rdOe_next;
  reg                  rdPend_reg;
  reg                  rdPend_next;
  reg  [ADDR_BITS-1:0] rdAddr_reg;
  reg  [ADDR_BITS-1:0] rdAddr_next;

  // decoded conditions
  wire                 inIdle;
  wire                 inAddr;
  wire                 inWord1;
  wire                 startBurst;
  wire                 startRead;

  // burst addresses and merged words
  wire [ADDR_BITS-1:0] addrFirst;
  wire [ADDR_BITS-1:0] addrSecond;
  wire [WB-1:0]        oldFirst;
  wire [WB-1:0]        oldSecond;
  wire [WB-1:0]        newFirst;
  wire [WB-1:0]        newSecond;

  // per-lane merge; a high select keeps the old lane
  function [WB-1:0] mergeLanes;
    input [WB-1:0]    oldW;
    input [WB-1:0]    newW;
    input [LANES-1:0] selN;
    integer i;
    begin
      mergeLanes = oldW;
      for (i = 0; i < LANES; i = i + 1) begin
        if (!selN[i]) begin
          mergeLanes[i*`DBW_LANE_BITS +: `DBW_LANE_BITS] =
            newW[i*`DBW_LANE_BITS +: `DBW_LANE_BITS];
        end
      end
    end
  endfunction

  // burst address step; drops the carry so the top address wraps to 0
  function [ADDR_BITS-1:0] addrPlus;
    input [ADDR_BITS-1:0] base;
    begin
      addrPlus = base + STEP;
    end
  endfunction

  // state decode
  assign inIdle     = (state_reg == ST_IDLE);
  assign inAddr     = (state_reg == ST_ADDR);
  assign inWord1    = (state_reg == ST_WORD1);

  // select counts only on the positive beat of an idle port
  assign startBurst = inIdle && posBeat && !write_port_sel_n;
  assign startRead  = posBeat && !readSel_n;

  // first word at the latched address, second one above it
  assign addrFirst  = addr_reg;
  assign addrSecond = addrPlus(addr_reg);

  // old contents feed the merge so masked lanes are kept
  assign oldFirst   = mem[addrFirst];
  assign oldSecond  = mem[addrSecond];
  assign newFirst   = mergeLanes(oldFirst, word0_reg, mask0_reg);
  assign newSecond  = mergeLanes(oldSecond, word1_reg, mask1_reg);

  // burst sequencing
  always @* begin
    state_next = ST_IDLE;
    case (state_reg)
      ST_IDLE: begin
        if (startBurst) begin
          state_next = ST_ADDR;
        end
      end
      ST_ADDR: begin
        state_next = ST_WORD1;
      end
      ST_WORD1: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // capture of the burst words; each word keeps its own mask
  always @* begin
    word0_next = word0_reg;
    mask0_next = mask0_reg;
    word1_next = word1_reg;
    mask1_next = mask1_reg;
    addr_next  = addr_reg;
    if (startBurst) begin
      word0_next = writeData;
      mask0_next = byte_lane_mask_n;
    end
    // select ignored mid-burst, so a pending write always finishes
    if (inAddr) begin
      word1_next = writeData;
      mask1_next = byte_lane_mask_n;
      addr_next  = writeAddr;
    end
  end

  // done pulses once per burst, masked or not
  always @* begin
    done_next = inWord1;
  end

  // state register
  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // burst capture registers
  always @(posedge clk) begin
    if (!rst_n) begin
      word0_reg <= {WB{1'h0}};
      mask0_reg <= {LANES{1'h1}};
      word1_reg <= {WB{1'h0}};
      mask1_reg <= {LANES{1'h1}};
      addr_reg  <= {ADDR_BITS{1'h0}};
      done_reg  <= 1'h0;
    end else begin
      word0_reg <= word0_next;
      mask0_reg <= mask0_next;
      word1_reg <= word1_next;
      mask1_reg <= mask1_next;
      addr_reg  <= addr_next;
      done_reg  <= done_next;
    end
  end

  // array write of both words once the burst is fully captured
  always @(posedge clk) begin
    if (inWord1) begin
      mem[addrFirst]  <= newFirst;
      // all-high masks hand the old word straight back
      mem[addrSecond] <= newSecond;
    end
  end

  // read request and data; not latency-accurate, kept minimal
  always @* begin
    rdPend_next = startRead;
    rdAddr_next = rdAddr_reg;
    rdOe_next   = rdPend_reg;
    rdData_next = rdData_reg;
    if (startRead) begin
      rdAddr_next = readAddr;
    end
    if (rdPend_reg) begin
      rdData_next = mem[rdAddr_reg];
    end
  end

  // read registers; enable stays low until a read comes
  always @(posedge clk) begin
    if (!rst_n) begin
      rdData_reg <= {WB{1'h0}};
      rdOe_reg   <= 1'h0;
      rdPend_reg <= 1'h0;
      rdAddr_reg <= {ADDR_BITS{1'h0}};
    end else begin
      rdData_reg <= rdData_next;
      rdOe_reg   <= rdOe_next;
      rdPend_reg <= rdPend_next;
      rdAddr_reg <= rdAddr_next;
    end
  end

  // outputs

  assign readData   = rdData_reg;
  assign readDataOe = rdOe_reg;
  assign writeBusy  = (state_reg != ST_IDLE);
  assign writeDone  = done_reg;

endmodule // dbw_write_port
`default_nettype wire

/* shared/dbw_map.vh */
// constants for the byte-lane masked write port
// assumes inclusion by bare name from the design file
`ifndef DBW_MAP_VH
`define DBW_MAP_VH
`define DBW_LANE_BITS      9
`define DBW_WORD_BITS      18
`define DBW_LANES          2
`define DBW_ADDR_BITS      6
`define DBW_ADDR_STEP      1
`define DBW_READ_LATENCY   2
`endif

/* test/dbw_ctrl_model.sv */
// controller model: drives two-word bursts
// assumes one clock; makes the beat phase
`timescale 1ns/100ps
`default_nettype none
module dbw_ctrl_model (
  input  wire logic        clk,
  output var  logic        posBeat,
  output var  logic        selN,
  output var  logic [1:0]  mask,
  output var  logic [17:0] dat,
  output var  logic [5:0]  adr
);
  initial begin
    posBeat = 1'b0;
    selN = 1'b1;
    mask = 2'h3;
    dat = 18'h00000;
    adr = 6'h00;
  end
  always @(posedge clk) posBeat <= ~posBeat;
  task automatic wr(input logic [5:0] a, input logic [17:0] d0,
    input logic [1:0] m0, input logic [17:0] d1, input logic [1:0] m1);
    do @(posedge clk); while (posBeat);
    selN <= 1'b0;
    dat <= d0;
    mask <= m0;
    @(posedge clk);
    selN <= 1'b1;
    dat <= d1;
    mask <= m1;
    adr <= a;
    @(posedge clk);
    dat <= ~d1;
    adr <= ~a;
  endtask
endmodule // dbw_ctrl_model
`default_nettype wire

/* test/dbw_write_port_chk.sv */
// timing checks on the write port
// assumes bind onto the design's ports
`timescale 1ns/100ps
`default_nettype none
module dbw_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic posBeat,
  input wire logic write_port_sel_n,
  input wire logic readSel_n,
  input wire logic readDataOe,
  input wire logic writeBusy,
  input wire logic writeDone
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire go = !writeBusy && posBeat && !write_port_sel_n;
  wire rd = posBeat && !readSel_n;
  property p_done; go |-> ##3 writeDone; endproperty
  a_done: assert property (p_done) else $error("no done");
  property p_busy; go |=> writeBusy[*2] ##1 !writeBusy; endproperty
  a_busy: assert property (p_busy) else $error("busy span");
  property p_one; writeDone |=> !writeDone; endproperty
  a_one: assert property (p_one) else $error("done long");
  property p_ign; writeDone |-> $past(go, 3); endproperty
  a_ign: assert property (p_ign) else $error("stray done");
  property p_idle; writeDone |-> !writeBusy; endproperty
  a_idle: assert property (p_idle) else $error("busy at done");
  property p_st; $rose(writeBusy) |-> $past(go); endproperty
  a_st: assert property (p_st) else $error("bad start");
  property p_oe; rd |-> ##[1:3] readDataOe; endproperty
  a_oe: assert property (p_oe) else $error("no read");
  property p_rst; disable iff (1'b0) !rst_n |=> !readDataOe; endproperty
  a_rst: assert property (p_rst) else $error("oe in reset");
endmodule // dbw_chk
bind dbw_write_port dbw_chk u_chk (.*);
`default_nettype wire

/* test/test_ddr_byte_write_mask.sv */
// bench: 18-bit and 36-bit masked write ports
// assumes the controller model on the 18-bit write side
`timescale 1ns/100ps
`default_nettype none
`define CHK(n,e,g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", n, e, g); end end
module test_ddr_byte_write_mask;
  logic clk = 0, rst_n = 0, rSel_n = 1;
  logic [5:0] rAdr = 6'h00;
  wire logic pb, wsN, oe, busy, done;
  wire logic [1:0] m;
  wire logic [17:0] d, q;
  wire logic [5:0] wa;
  int err_total = 0, n_tests = 0;
  // 36-bit port shares beat and read strobe with the 18-bit one
  logic wSel36_n = 1;
  logic [3:0] m36 = 4'hF;
  logic [35:0] d36 = 36'h000000000;
  logic [5:0] a36 = 6'h00;
  wire logic [35:0] q36;
  wire logic oe36;
  dbw_ctrl_model u_ctl (.clk(clk), .posBeat(pb), .selN(wsN), .mask(m),
    .dat(d), .adr(wa));
  dbw_write_port u_dut (.clk(clk), .rst_n(rst_n), .posBeat(pb),
    .write_port_sel_n(wsN), .byte_lane_mask_n(m), .writeData(d),
    .writeAddr(wa), .readSel_n(rSel_n), .readAddr(rAdr), .readData(q),
    .readDataOe(oe), .writeBusy(busy), .writeDone(done));
  dbw_write_port #(.LANES(4), .ADDR_BITS(6)) u_dut36 (.clk(clk),
    .rst_n(rst_n), .posBeat(pb), .write_port_sel_n(wSel36_n),
    .byte_lane_mask_n(m36), .writeData(d36), .writeAddr(a36),
    .readSel_n(rSel_n), .readAddr(rAdr), .readData(q36),
    .readDataOe(oe36), .writeBusy(), .writeDone());
  // free-running, never stopped, so no stop level to keep
  initial forever #12.5 clk = ~clk;
  task automatic wr36(input logic [5:0] a, input logic [35:0] w0,
    input logic [3:0] k0, input logic [35:0] w1, input logic [3:0] k1);
    do @(posedge clk); while (pb);
    wSel36_n <= 1'b0;
    d36 <= w0;
    m36 <= k0;
    @(posedge clk);
    wSel36_n <= 1'b1;
    d36 <= w1;
    m36 <= k1;
    a36 <= a;
    @(posedge clk);
    m36 <= 4'hF;
  endtask
  task automatic rd36(input logic [5:0] a, input logic [35:0] e);
    do @(posedge clk); while (pb);
    rSel_n <= 1'b0;
    rAdr <= a;
    @(posedge clk);
    rSel_n <= 1'b1;
    for (int i = 0; i < 4 && oe36 !== 1'b1; i++) @(posedge clk);
    `CHK("readData36", e, q36)
  endtask
  task t_wide();
    wr36(6'h10, {9'h111, 9'h122, 9'h133, 9'h144}, 4'h0, 36'h0, 4'h0);
    wr36(6'h10, {9'h1AA, 9'h1BB, 9'h1CC, 9'h1DD}, 4'h5,
      36'hFFFFFFFFF, 4'hF);
    rd36(6'h10, {9'h1AA, 9'h122, 9'h1CC, 9'h144});
    rd36(6'h11, 36'h000000000);
  endtask
  task automatic rd(input logic [5:0] a, input logic [17:0] e);
    do @(posedge clk); while (pb);
    rSel_n <= 1'b0;
    rAdr <= a;
    @(posedge clk);
    rSel_n <= 1'b1;
    for (int i = 0; i < 4 && oe !== 1'b1; i++) @(posedge clk);
    `CHK("readData", e, q)
  endtask
  task t_reset();
    repeat (12) @(posedge clk);
    `CHK("oe", 1'b0, oe)
    `CHK("busy", 1'b0, busy)
    rst_n <= 1'b1;
  endtask
  task t_full();
    u_ctl.wr(6'h05, {9'h155, 9'h0AA}, 2'h0, {9'h0F0, 9'h00F}, 2'h0);
    rd(6'h05, {9'h155, 9'h0AA});
    rd(6'h06, {9'h0F0, 9'h00F});
  endtask
  // back-to-back: lanes differ per word, then a fully masked burst
  task t_mask();
    u_ctl.wr(6'h05, 18'h3FFFF, 2'h2, 18'h00000, 2'h1);
    u_ctl.wr(6'h05, 18'h12345, 2'h3, 18'h12345, 2'h3);
    rd(6'h05, {9'h155, 9'h1FF});
    rd(6'h06, {9'h000, 9'h00F});
  endtask
  task t_wrap();
    u_ctl.wr(6'h3F, 18'h0ABCD, 2'h0, 18'h31234, 2'h0);
    rd(6'h3F, 18'h0ABCD);
    rd(6'h00, 18'h31234);
  endtask
  task test_done();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // far beyond the fewer than one hundred cycles the tests use
  initial begin
    #50000;
    err_total++;
    test_done();
  end
  initial begin
    t_reset();
    t_full();
    t_mask();
    t_wrap();
    t_wide();
    test_done();
  end
endmodule // test_ddr_byte_write_mask
`default_nettype wire
